// >>> logic/btob_map.vh
/*
 * register offsets, field positions, reset values and opcodes shared by the
 * bit-invert / overflow-branch execution unit.
 * assumes: included by bare name from the design files under logic/.
 */
// Behaviour
// (RULE_01) bit_invert_op inverts only the selected bit
// (RULE_02) access bit picks access bank or bank_select_reg
// (RULE_03) extended set, f<=5Fh: indexed literal offset
// (RULE_04) branch only when overflow flag is 1
// (RULE_05) target is PC+2 plus twice offset
// (RULE_06) branch one cycle, taken adds nop cycle
// (RULE_07) branch leaves every status flag unchanged
// (RULE_08) invert: decode, read, invert, write back
`ifndef BTOB_MAP_VH
`define BTOB_MAP_VH

// ------------------------------------------------------------------
// register word indices: the byte address is four times the index
// ------------------------------------------------------------------
`define BTOB_OFF_CTRL       4'h0
`define BTOB_OFF_BANK       4'h1
`define BTOB_OFF_INDEX      4'h2
`define BTOB_OFF_PC         4'h3
`define BTOB_OFF_STATUS     4'h4
`define BTOB_OFF_COUNT      4'h5

// ------------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------------
`define BTOB_CTRL_RUN       0
`define BTOB_CTRL_EXT       1
`define BTOB_CTRL_RST       2'h0
`define BTOB_BANK_RST       4'h0
`define BTOB_INDEX_RST      12'h000
`define BTOB_PC_RST         21'h000000

// ------------------------------------------------------------------
// opcodes and addressing
// ------------------------------------------------------------------
`define BTOB_OP_INVERT      4'h7
`define BTOB_OP_BRANCH_OVF  8'he4
`define BTOB_INDEX_LIMIT    8'h5f
`define BTOB_ACCESS_HIGH    4'hf
`define BTOB_ACCESS_LOW     4'h0
`define BTOB_PC_STEP        21'h000002

`define BTOB_RESP_OKAY      2'h0
`define BTOB_RESP_SLVERR    2'h2

`endif

// >>> logic/btob_phase_gen.v
/*
 * phase generator: splits the instruction cycle into four phases and gives
 * a one-cycle strobe in the last cycle of each phase.
 * assumes: single clock clk, synchronous active-low reset nrst.
 */
`timescale 1ns/10ps
module btob_phase_gen #(
	parameter CLKS_PER_PHASE = 1
) (
	input  wire       clk,
	input  wire       nrst,
	output reg  [1:0] phase,
	output reg        phaseStrobe
);
	reg  [7:0] divCount;

	// ------------------------------------------------------------------
	// divider
	// ------------------------------------------------------------------
	// strobe marks the edge at which 'phase' is acted on
	always @(posedge clk) begin
		if (!nrst) begin
			divCount    <= 8'h00;
			phase       <= 2'h0;
			phaseStrobe <= 1'b0;
		end else if (divCount == CLKS_PER_PHASE[7:0] - 8'h01) begin
			divCount    <= 8'h00;
			phaseStrobe <= 1'b1;
			if (phaseStrobe)
				phase <= phase + 2'h1;
		end else begin
			divCount    <= divCount + 8'h01;
			if (phaseStrobe)
				phase <= phase + 2'h1;
			phaseStrobe <= 1'b0;
		end
	end
endmodule // btob_phase_gen

// >>> logic/btob_exec.v
/*
 * execution unit for the bit-invert and branch-on-overflow instructions,
 * with an AXI4-Lite register slave.
 * assumes: instruction word and overflow flag come from logic on clk;
 * data memory answers memRdata combinationally in the cycle memRdEn is high.
 */
`timescale 1ns/10ps
`include "btob_map.vh"
module btob_exec #(
	parameter CLKS_PER_PHASE = 1
) (
	input  wire        clk,
	input  wire        nrst,
	// instruction feed
	input  wire [15:0] instrWord,
	input  wire        instrValid,
	output reg         instrTaken,
	input  wire        ovfFlag,
	// data memory
	output reg  [11:0] memAddr,
	output reg         memRdEn,
	input  wire [7:0]  memRdata,
	output reg         memWrEn,
	output reg  [7:0]  memWdata,
	// program counter
	output reg  [20:0] pc,
	output reg         pcLoad,
	// AXI4-Lite slave
	input  wire [5:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [5:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	localparam EX_IDLE   = 2'h0;
	localparam EX_INVERT = 2'h1;
	localparam EX_BRANCH = 2'h2;
	localparam EX_NOP    = 2'h3;

	wire [1:0]  phase;
	wire        phaseStrobe;
	reg  [1:0]  exState;
	reg  [15:0] opWord;
	reg  [7:0]  workByte;
	reg  [20:0] target;
	reg         nopPending;
	reg         lastTaken;
	reg  [15:0] execCount;
	reg  [1:0]  ctrl;
	reg  [3:0]  bankSelectReg;
	reg  [11:0] indexBase;
	reg  [11:0] next_addr;
	reg  [7:0]  invertMask;
	reg  [5:0]  wrAddr;
	reg         wrAddrHeld;
	reg  [31:0] wrData;
	reg  [3:0]  wrStrb;
	reg         wrDataHeld;
	reg  [31:0] next_rdata;
	reg         rdHit;
	reg         wrHit;
	wire [20:0] pcWrValue;
	wire        pcWrite;

	btob_phase_gen #(
		.CLKS_PER_PHASE (CLKS_PER_PHASE)
	) u_phase (
		.clk         (clk),
		.nrst        (nrst),
		.phase       (phase),
		.phaseStrobe (phaseStrobe)
	);

	// ------------------------------------------------------------------
	// operand decode
	// ------------------------------------------------------------------
	always @* begin
		// (RULE_02) bank from access bit
		if (opWord[8])
			next_addr = {bankSelectReg, opWord[7:0]};
		else if (opWord[7:0] > `BTOB_INDEX_LIMIT)
			next_addr = {`BTOB_ACCESS_HIGH, opWord[7:0]};
		else
			next_addr = {`BTOB_ACCESS_LOW, opWord[7:0]};
		// (RULE_03) indexed literal offset
		if (!opWord[8] && ctrl[`BTOB_CTRL_EXT] && opWord[7:0] <= `BTOB_INDEX_LIMIT)
			next_addr = indexBase + {4'h0, opWord[7:0]};
	end

	always @* begin
		invertMask = 8'h00;
		invertMask[opWord[11:9]] = 1'b1;
	end

	// ------------------------------------------------------------------
	// four-phase sequencer
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			exState    <= EX_IDLE;
			opWord     <= 16'h0000;
			workByte   <= 8'h00;
			target     <= `BTOB_PC_RST;
			nopPending <= 1'b0;
			lastTaken  <= 1'b0;
			execCount  <= 16'h0000;
			instrTaken <= 1'b0;
			memAddr    <= 12'h000;
			memRdEn    <= 1'b0;
			memWrEn    <= 1'b0;
			memWdata   <= 8'h00;
			pc         <= `BTOB_PC_RST;
			pcLoad     <= 1'b0;
		end else begin
			instrTaken <= 1'b0;
			memRdEn    <= 1'b0;
			memWrEn    <= 1'b0;
			pcLoad     <= 1'b0;
			if (pcWrite)
				pc <= pcWrValue;
			if (phaseStrobe) begin
				case (phase)
				2'h0: begin
					// (RULE_06) taken branch follows with nop
					if (nopPending) begin
						nopPending <= 1'b0;
						exState    <= EX_NOP;
					end else if (ctrl[`BTOB_CTRL_RUN] && instrValid) begin
						opWord     <= instrWord;
						instrTaken <= 1'b1;
						pc         <= pc + `BTOB_PC_STEP;
						execCount  <= execCount + 16'h0001;
						// (RULE_08) decode in first phase
						if (instrWord[15:12] == `BTOB_OP_INVERT)
							exState <= EX_INVERT;
						else if (instrWord[15:8] == `BTOB_OP_BRANCH_OVF)
							exState <= EX_BRANCH;
						else
							exState <= EX_IDLE;
					end else begin
						exState <= EX_IDLE;
					end
				end
				2'h1: begin
					// (RULE_08) read register in second phase
					if (exState == EX_INVERT) begin
						memAddr <= next_addr;
						memRdEn <= 1'b1;
					end
				end
				2'h2: begin
					// (RULE_01) flip the selected bit only
					if (exState == EX_INVERT)
						workByte <= memRdata ^ invertMask;
					// (RULE_05) target from advanced pc
					if (exState == EX_BRANCH)
						target <= pc + {{12{opWord[7]}}, opWord[7:0], 1'b0};
				end
				default: begin
					// (RULE_08) write back in fourth phase
					if (exState == EX_INVERT) begin
						memWdata <= workByte;
						memWrEn  <= 1'b1;
					end
					// (RULE_04) branch only on overflow set
					if (exState == EX_BRANCH) begin
						lastTaken <= ovfFlag;
						if (ovfFlag) begin
							pc         <= target;
							pcLoad     <= 1'b1;
							nopPending <= 1'b1;
						end
					end
					// (RULE_07) no status flag is driven
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	// address and data may arrive in either order; each is held until both are in
	always @* begin
		wrHit = (wrAddr[5:2] <= `BTOB_OFF_PC) && (wrAddr[1:0] == 2'h0);
	end

	assign pcWrite   = wrAddrHeld && wrDataHeld && !s_axi_bvalid && wrHit &&
		(wrAddr[5:2] == `BTOB_OFF_PC) && (wrStrb == 4'hf);
	assign pcWrValue = wrData[20:0];

	always @(posedge clk) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BTOB_RESP_OKAY;
			wrAddr        <= 6'h00;
			wrAddrHeld    <= 1'b0;
			wrData        <= 32'h00000000;
			wrStrb        <= 4'h0;
			wrDataHeld    <= 1'b0;
			ctrl          <= `BTOB_CTRL_RST;
			bankSelectReg <= `BTOB_BANK_RST;
			indexBase     <= `BTOB_INDEX_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wrAddr        <= s_axi_awaddr;
				wrAddrHeld    <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wrData       <= s_axi_wdata;
				wrStrb       <= s_axi_wstrb;
				wrDataHeld   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wrAddrHeld && wrDataHeld && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? `BTOB_RESP_OKAY : `BTOB_RESP_SLVERR;
				if (wrHit && wrStrb[0]) begin
					case (wrAddr[5:2])
					`BTOB_OFF_CTRL:  ctrl          <= wrData[1:0];
					`BTOB_OFF_BANK:  bankSelectReg <= wrData[3:0];
					`BTOB_OFF_INDEX: indexBase[7:0] <= wrData[7:0];
					default:         ;
					endcase
				end
				if (wrHit && wrStrb[1] && wrAddr[5:2] == `BTOB_OFF_INDEX)
					indexBase[11:8] <= wrData[11:8];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				wrAddrHeld    <= 1'b0;
				wrDataHeld    <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	always @* begin
		next_rdata = 32'h00000000;
		rdHit      = (s_axi_araddr[1:0] == 2'h0);
		case (s_axi_araddr[5:2])
		`BTOB_OFF_CTRL:   next_rdata[1:0]   = ctrl;
		`BTOB_OFF_BANK:   next_rdata[3:0]   = bankSelectReg;
		`BTOB_OFF_INDEX:  next_rdata[11:0]  = indexBase;
		`BTOB_OFF_PC:     next_rdata[20:0]  = pc;
		`BTOB_OFF_STATUS: next_rdata[5:0]   = {exState, phase, nopPending, lastTaken};
		`BTOB_OFF_COUNT:  next_rdata[15:0]  = execCount;
		default:          rdHit             = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `BTOB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdHit ? next_rdata : 32'h00000000;
			s_axi_rresp   <= rdHit ? `BTOB_RESP_OKAY : `BTOB_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // btob_exec

// >>> testbench/btob_exec_assertions.sv
/* checker for btob_exec: invert and overflow-branch timing at the ports.
   assumes CLKS_PER_PHASE of 1 and a bind into every btob_exec. */
`timescale 1ns/10ps
module btob_exec_assertions #(
	parameter CLKS_PER_PHASE = 1
) (
	input wire        clk,
	input wire        nrst,
	input wire [15:0] instrWord,
	input wire        instrTaken,
	input wire        ovfFlag,
	input wire [11:0] memAddr,
	input wire        memRdEn,
	input wire [7:0]  memRdata,
	input wire        memWrEn,
	input wire [7:0]  memWdata,
	input wire [20:0] pc,
	input wire        pcLoad
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// feed may drop the word once taken, so keep our own copy
	reg [15:0] wordQ;
	always @(posedge clk) begin
		if (instrTaken)
			wordQ <= $past(instrWord);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence sWriteBack;
		##2 memWrEn;
	endsequence
	sequence sNopSlot;
		##1 !instrTaken [*4];
	endsequence
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// one bit flips
	inv_one_bit_a: assert property (
		memWrEn |-> $countones(memWdata ^ $past(memRdata, 2)) == 1)
		else $error("write-back flips other than one bit");
	read_write_a: assert property (memRdEn |-> sWriteBack)
		else $error("no write-back two cycles after read");
	take_gap_a: assert property (instrTaken |=> !instrTaken [*3])
		else $error("words taken closer than four phases");
	pc_step_a: assert property (instrTaken |-> pc == $past(pc) + 21'h2)
		else $error("pc not advanced by two");
	br_target_a: assert property (
		pcLoad |-> pc == $past(pc) + {{12{wordQ[7]}}, wordQ[7:0], 1'b0})
		else $error("branch target wrong");
	br_ovf_a: assert property (
		pcLoad |-> $past(ovfFlag) && wordQ[15:8] == 8'he4)
		else $error("pc loaded without overflow branch");
	br_nop_a: assert property (pcLoad |-> sNopSlot)
		else $error("word taken in nop cycle");
	bank_high_a: assert property (
		memRdEn && !wordQ[8] && wordQ[7:0] > 8'h5f |-> memAddr == {4'hf, wordQ[7:0]})
		else $error("access bank address wrong");
endmodule // btob_exec_assertions
bind btob_exec btob_exec_assertions #(.CLKS_PER_PHASE(CLKS_PER_PHASE)) u_chk (
	.clk, .nrst, .instrWord, .instrTaken, .ovfFlag, .memAddr, .memRdEn,
	.memRdata, .memWrEn, .memWdata, .pc, .pcLoad);

// >>> testbench/btob_exec_tb.sv
/* self-checking bench for btob_exec: axi setup, invert and branch runs.
   assumes memory answers combinationally from memAddr. */
`timescale 1ns/10ps
module btob_exec_tb;
	logic clk, nrst, instrValid, ovfFlag, instrTaken, memRdEn, memWrEn, pcLoad;
	logic [15:0] instrWord;
	logic [11:0] memAddr, lastAddr;
	logic [7:0]  memRdata, memWdata, lastData;
	logic [20:0] pc, expPc;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int num_errors = 0;
	int samples_checked = 0;
	btob_exec u_dut (.clk, .nrst, .instrWord, .instrValid, .instrTaken, .ovfFlag,
		.memAddr, .memRdEn, .memRdata, .memWrEn, .memWdata, .pc, .pcLoad,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// pattern memory: each low address byte reads back a distinct byte
	assign memRdata = memAddr[7:0] ^ 8'h5a;
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (memWrEn) begin
			lastAddr <= memAddr;
			lastData <= memWdata;
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task stop_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string what, input [31:0] exp, input [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr(input [5:0] a, input [31:0] d);
		int i;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 0;
		if (i == 50) begin num_errors++; stop_test; end
	endtask
	task rdr(input [5:0] a);
		int i;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
		if (i == 50) begin num_errors++; stop_test; end
	endtask
	// offers one word, waits for the take, then lets the cycle finish
	task exec(input [15:0] w);
		int i;
		@(posedge clk);
		instrWord <= w;
		instrValid <= 1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (instrTaken) break;
		end
		instrValid <= 0;
		expPc += 21'h2;
		if (i == 40) begin num_errors++; stop_test; end
		repeat (8) @(posedge clk);
	endtask
	task inv(input [7:0] f, input [2:0] b, input a, input [11:0] ea);
		exec({4'h7, b, a, f});
		chk("memAddr", 32'(ea), 32'(lastAddr));
		chk("memWdata", 32'((f ^ 8'h5a) ^ (8'h01 << b)), 32'(lastData));
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 0; instrValid = 0; ovfFlag = 0; instrWord = 16'h0000; s_axi_wstrb = 4'hf;
		s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_awvalid = 0;
		s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0; s_axi_rready = 0;
		repeat (12) @(posedge clk);
		nrst <= 1;
		rdr(6'h18);
		chk("unmapped rresp", 32'h2, 32'(resp));
		wr(6'h10, 32'h0000_0001);
		chk("status bresp", 32'h2, 32'(resp));
		wr(6'h04, 32'h0000_0005);
		wr(6'h08, 32'h0000_0300);
		wr(6'h0c, 32'h0000_0100);
		expPc = 21'h000100;
		rdr(6'h04);
		chk("bank", 32'h5, rd);
		wr(6'h00, 32'h0000_0001);
		for (int b = 0; b < 8; b++)
			inv(8'h33, 3'(b), 1'b1, 12'h533);
		inv(8'h80, 3'h4, 1'b0, 12'hf80);
		inv(8'h5f, 3'h0, 1'b0, 12'h05f);
		wr(6'h00, 32'h0000_0003);
		inv(8'h5f, 3'h7, 1'b0, 12'h35f);
		inv(8'h60, 3'h2, 1'b0, 12'hf60);
		inv(8'h10, 3'h1, 1'b1, 12'h510);
		chk("pc", 32'(expPc), 32'(pc));
		exec(16'he405);
		chk("pc", 32'(expPc), 32'(pc));
		rdr(6'h10);
		chk("last taken", 32'h0, {31'h0, rd[0]});
		ovfFlag <= 1;
		exec(16'he480);
		expPc += 21'h1fff00;
		chk("pc", 32'(expPc), 32'(pc));
		exec(16'he47f);
		expPc += 21'h0000fe;
		chk("pc", 32'(expPc), 32'(pc));
		rdr(6'h10);
		chk("last taken", 32'h1, {31'h0, rd[0]});
		// an opcode outside the two is taken and stepped over, with no memory write
		exec(16'h0000);
		chk("memAddr", 32'h510, 32'(lastAddr));
		chk("pc", 32'(expPc), 32'(pc));
		rdr(6'h0c);
		chk("pc reg", 32'(expPc), rd);
		rdr(6'h14);
		chk("count", 32'h11, rd);
		stop_test;
	end
endmodule // btob_exec_tb
